// *** rtl/ilv_top.sv ***
// interrupt latching, vector and priority selection with ahb-lite registers
//
// Functional notes
// - nonmaskable request pin is always level sensitive, never edge detected
// - maskable request pin works as low level or edge input by configuration
// - servicing with no active source left fetches the trap vector
// - in edge mode a falling edge is held in an internal latch
// - the edge latch clears itself when that request is serviced
// - each peripheral source is held in a flag until cleared
// - fixed unmaskable vectors: reset, clock monitor, watchdog, trap, software, x pin
// - elevation value equal to a vector low byte makes that source highest
// - serial transfer complete uses slot d8, gated by local enable and mask
// - standard map: modulus underflow uses slot cc with its local enable
// - standard map: second accumulator overflow uses slot ca with local enable
// - can map: wakeup d0, errors c8, receive c6, transmit c4 replace others
// - elevation register takes writes only while the global mask is set
// - unimplemented or too high elevation value makes the request pin highest
// - reset loads elevation f2 and makes the request pin level sensitive
// - edge select one means falling edges only, zero means low level
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ilv_defs.svh"

module ilv_top #(
  parameter bit CAN_MAP = 1'b0
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [`ILV_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nonmaskable_request_pin_n,
  input wire logic maskable_request_pin_n,
  input wire logic [`ILV_SLOTS-1:1] periph_event,
  input wire logic clkmon_fail,
  input wire logic watchdog_fail,
  input wire logic special_mode,
  input wire logic cpu_i_mask,
  input wire logic cpu_x_mask,
  input wire logic software_trap_instruction,
  input wire logic illegal_opcode,
  input wire logic service_ack,
  output logic maskable_req,
  output logic nonmaskable_req,
  output logic [15:0] vector_addr,
  output logic vector_valid,
  output logic irq_out
);

  // slots 11..13 (dc, da, d8) are the same in both maps; 19..23 differ
  localparam logic [`ILV_SLOTS-1:0] IMPL = CAN_MAP ? `ILV_IMPL_CAN : `ILV_IMPL_STD;

  ////////////////////////////////////////////////////////////////////////////
  // pins

  logic [1:0] pins_s;
  logic irq_prev, irq_fall, irq_low, nonmaskable_request_pin_low, edge_latch, clr_edge;

  ilv_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync
  (
    .clk(hclk),
    .rst_n(hresetn),
    .din({nonmaskable_request_pin_n, maskable_request_pin_n}),
    .dout(pins_s)
  );

  assign irq_low = ~pins_s[0];
  assign nonmaskable_request_pin_low = ~pins_s[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_prev <= 1'b1;
    else
      irq_prev <= pins_s[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [`ILV_CTRL_W-1:0] ctrl;
  logic edge_wr_seen;
  logic [7:0] elev;
  logic [`ILV_SLOTS-1:1] local_en;
  logic [`ILV_SLOTS-1:1] flags;
  logic [`ILV_EV_W-1:0] int_stat, int_en, events, next_int_stat;

  logic edge_mode, connect, clkmon_hit;

  assign edge_mode = ctrl[`ILV_CTRL_EDGE];
  assign connect = ctrl[`ILV_CTRL_CONNECT];
  assign clkmon_hit = clkmon_fail & (ctrl[`ILV_CTRL_CME] | ctrl[`ILV_CTRL_FORCED_CLOCK_MONITOR_ENABLE]);

  // edge capture is only armed while the pin is connected and edge mode is on
  assign irq_fall = irq_prev & ~pins_s[0] & edge_mode & connect;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay

  logic acc;
  logic wr_pend;
  logic [`ILV_ADDR_W-1:0] wr_addr;
  logic [`ILV_ADDR_W-1:0] word_addr;
  logic [31:0] rd_mux;
  logic wr_ctrl, wr_elev, wr_en, wr_fclr, wr_iclr, wr_ien;

  assign acc = hsel & hready & htrans[1];
  assign word_addr = {haddr[`ILV_ADDR_W-1:2], 2'b00};

  assign wr_ctrl = wr_pend && (wr_addr == `ILV_OFS_CTRL);
  assign wr_elev = wr_pend && (wr_addr == `ILV_OFS_ELEV);
  assign wr_en = wr_pend && (wr_addr == `ILV_OFS_LOCAL_EN);
  assign wr_fclr = wr_pend && (wr_addr == `ILV_OFS_FLAG_CLR);
  assign wr_iclr = wr_pend && (wr_addr == `ILV_OFS_INT_CLR);
  assign wr_ien = wr_pend && (wr_addr == `ILV_OFS_INT_EN);

  always_comb
  begin
    rd_mux = '0;
    unique case (word_addr)
      `ILV_OFS_CTRL: rd_mux = 32'(ctrl);
      `ILV_OFS_ELEV: rd_mux = 32'(elev);
      `ILV_OFS_LOCAL_EN: rd_mux = 32'({local_en, 1'b0});
      `ILV_OFS_FLAGS: rd_mux = 32'({flags, 1'b0});
      `ILV_OFS_INT_STAT: rd_mux = 32'(int_stat);
      `ILV_OFS_INT_EN: rd_mux = 32'(int_en);
      `ILV_OFS_VECTOR: rd_mux = 32'(vector_addr);
      `ILV_OFS_PINS: rd_mux = 32'({edge_latch, pins_s});
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= acc & hwrite & (hsize == `ILV_HSIZE_WORD);
      if (acc)
      begin
        wr_addr <= word_addr;
        hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and elevation registers

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `ILV_CTRL_RESET;
      edge_wr_seen <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      edge_wr_seen <= 1'b1;
      // once in normal modes; in special modes the first write is dropped
      if (special_mode ? edge_wr_seen : !edge_wr_seen)
        ctrl[`ILV_CTRL_EDGE] <= hwdata[`ILV_CTRL_EDGE];
      ctrl[`ILV_CTRL_CONNECT] <= hwdata[`ILV_CTRL_CONNECT];
      ctrl[`ILV_CTRL_CME] <= hwdata[`ILV_CTRL_CME];
      ctrl[`ILV_CTRL_FORCED_CLOCK_MONITOR_ENABLE] <= hwdata[`ILV_CTRL_FORCED_CLOCK_MONITOR_ENABLE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      elev <= `ILV_ELEV_RESET;
    else if (wr_elev && cpu_i_mask)
      elev <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      local_en <= '0;
    else if (wr_en)
      local_en <= hwdata[`ILV_SLOTS-1:1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // request latching

  // a flag raised in the same cycle as its clear stays set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags <= '0;
    else
      flags <= (flags & ~(wr_fclr ? hwdata[`ILV_SLOTS-1:1] : '0))
        | (periph_event & IMPL[`ILV_SLOTS-1:1]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_latch <= 1'b0;
    else if (irq_fall)
      edge_latch <= 1'b1;
    else if (clr_edge || !edge_mode)
      edge_latch <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority selection

  ilv_sel_if sel_bus();

  // the pin is level sensitive unless edge mode is selected
  assign sel_bus.pending = {flags & local_en, connect & (edge_mode ? edge_latch : irq_low)};
  assign sel_bus.elev = elev;

  ilv_prio_select #(.IMPL(IMPL)) u_sel
  (
    .sel(sel_bus.sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // vector fetch

  logic mask_hit, no_source;
  logic [7:0] slot_byte;
  ilv_pkg::ilv_vector_type next_vector;

  assign mask_hit = sel_bus.win_any & ~cpu_i_mask;
  assign slot_byte = `ILV_ELEV_TOP - {2'b00, sel_bus.win_idx, 1'b0};

  always_comb
  begin
    no_source = 1'b0;
    if (clkmon_hit)
      next_vector = `ILV_VEC_CLKMON;
    else if (watchdog_fail)
      next_vector = `ILV_VEC_WDOG;
    else if (illegal_opcode)
      next_vector = `ILV_VEC_TRAP;
    else if (software_trap_instruction)
      next_vector = `ILV_VEC_SWI;
    else if (nonmaskable_request_pin_low && !cpu_x_mask)
      next_vector = `ILV_VEC_NONMASKABLE_REQUEST_PIN;
    else if (mask_hit)
      next_vector = {`ILV_VEC_PAGE, slot_byte};
    else
    begin
      // the request went away between recognition and fetch
      next_vector = `ILV_VEC_TRAP;
      no_source = 1'b1;
    end
  end

  // besides leaving edge mode, only a service that really picks the pin slot drops the edge latch
  assign clr_edge = service_ack & (next_vector == {`ILV_VEC_PAGE, `ILV_ELEV_TOP})
    & edge_mode;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_addr <= `ILV_VEC_RESET;
      vector_valid <= 1'b0;
    end
    else
    begin
      vector_valid <= service_ack;
      if (service_ack)
        vector_addr <= next_vector;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      maskable_req <= 1'b0;
      nonmaskable_req <= 1'b0;
    end
    else
    begin
      maskable_req <= mask_hit;
      nonmaskable_req <= (nonmaskable_request_pin_low & ~cpu_x_mask) | clkmon_hit | watchdog_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block interrupt status

  always_comb
  begin
    events = '0;
    events[`ILV_EV_TRAP] = service_ack & no_source;
    events[`ILV_EV_SERVED] = service_ack;
    events[`ILV_EV_EDGE] = irq_fall;
    // set beats clear in the same cycle
    next_int_stat = (int_stat & ~(wr_iclr ? hwdata[`ILV_EV_W-1:0] : '0)) | events;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_stat <= '0;
      int_en <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      int_stat <= next_int_stat;
      if (wr_ien)
        int_en <= hwdata[`ILV_EV_W-1:0];
      irq_out <= |(int_stat & int_en);
    end
  end

endmodule // ilv_top

// *** shared/ilv_defs.svh ***
// constants of the interrupt latch and vector map block
`ifndef ILV_DEFS_SVH
`define ILV_DEFS_SVH

// number of maskable vector slots, slot i has vector low byte f2 - 2*i
`define ILV_SLOTS 24
`define ILV_SLOT_W 5

// register word offsets on the bus
`define ILV_OFS_CTRL 8'h00
`define ILV_OFS_ELEV 8'h04
`define ILV_OFS_LOCAL_EN 8'h08
`define ILV_OFS_FLAGS 8'h0c
`define ILV_OFS_FLAG_CLR 8'h10
`define ILV_OFS_INT_STAT 8'h14
`define ILV_OFS_INT_CLR 8'h18
`define ILV_OFS_INT_EN 8'h1c
`define ILV_OFS_VECTOR 8'h20
`define ILV_OFS_PINS 8'h24

// control register fields
`define ILV_CTRL_EDGE 0
`define ILV_CTRL_CONNECT 1
`define ILV_CTRL_CME 2
`define ILV_CTRL_FORCED_CLOCK_MONITOR_ENABLE 3
`define ILV_CTRL_W 4
`define ILV_CTRL_RESET 4'h2

// interrupt status fields
`define ILV_EV_TRAP 0
`define ILV_EV_SERVED 1
`define ILV_EV_EDGE 2
`define ILV_EV_W 3

// fixed vectors
`define ILV_VEC_RESET 16'hfffe
`define ILV_VEC_CLKMON 16'hfffc
`define ILV_VEC_WDOG 16'hfffa
`define ILV_VEC_TRAP 16'hfff8
`define ILV_VEC_SWI 16'hfff6
`define ILV_VEC_NONMASKABLE_REQUEST_PIN 16'hfff4
`define ILV_VEC_PAGE 8'hff

// elevation values
`define ILV_ELEV_RESET 8'hf2
`define ILV_ELEV_TOP 8'hf2
`define ILV_ELEV_LOW 8'hc4

// slots that carry a source in each map
`define ILV_IMPL_STD 24'h1b7fff
`define ILV_IMPL_CAN 24'he37fff

// bus constants
`define ILV_HSIZE_WORD 3'b010
`define ILV_ADDR_W 8

`endif

// *** shared/ilv_pkg.sv ***
// types shared by the interrupt latch and vector map block
`include "ilv_defs.svh"

package ilv_pkg;
  typedef logic [15:0] ilv_vector_type;
  typedef logic [`ILV_SLOT_W-1:0] ilv_slot_type;
  typedef logic [`ILV_SLOTS-1:0] ilv_mask_type;
endpackage

// *** shared/ilv_sel_if.sv ***
// interface between the latch logic and the priority selector
`timescale 1ns/10ps
`include "ilv_defs.svh"

interface ilv_sel_if;
  ilv_pkg::ilv_mask_type pending;
  logic [7:0] elev;
  ilv_pkg::ilv_slot_type win_idx;
  logic win_any;

  modport latch
  (
    output pending,
    output elev,
    input win_idx,
    input win_any
  );

  modport sel
  (
    input pending,
    input elev,
    output win_idx,
    output win_any
  );
endinterface

// *** rtl/ilv_sync.sv ***
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps

module ilv_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // ilv_sync

// *** rtl/ilv_prio_select.sv ***
// maskable source priority selector with elevation
`timescale 1ns/10ps
`include "ilv_defs.svh"

module ilv_prio_select #(
  parameter logic [`ILV_SLOTS-1:0] IMPL = `ILV_IMPL_STD
)
(
  ilv_sel_if.sel sel
);

  logic [7:0] diff;
  ilv_pkg::ilv_slot_type elev_idx;
  ilv_pkg::ilv_slot_type top_idx;
  logic elev_ok;

  always_comb
  begin
    diff = `ILV_ELEV_TOP - sel.elev;
    elev_idx = diff[`ILV_SLOT_W:1];
    // odd, out of range or sourceless values fall back to the request pin
    elev_ok = (sel.elev <= `ILV_ELEV_TOP) && (sel.elev >= `ILV_ELEV_LOW) && !sel.elev[0]
      && IMPL[elev_idx];
    top_idx = elev_ok ? elev_idx : '0;
    sel.win_any = |sel.pending;
    sel.win_idx = '0;
    // lowest slot is highest vector, so scan downward and let lower slots win
    for (int i = `ILV_SLOTS - 1; i >= 0; i--)
    begin
      if (sel.pending[i])
      begin
        sel.win_idx = ilv_pkg::ilv_slot_type'(i);
      end
    end
    if (sel.pending[top_idx])
    begin
      sel.win_idx = top_idx;
    end
  end

endmodule // ilv_prio_select

// *** sim/ilv_asserts.sv ***
// concurrent checks on the top ports of the interrupt latch and vector map
`timescale 1ns/10ps

module ilv_asserts
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic nonmaskable_request_pin_n,
  input wire logic cpu_x_mask,
  input wire logic cpu_i_mask,
  input wire logic clkmon_fail,
  input wire logic watchdog_fail,
  input wire logic illegal_opcode,
  input wire logic software_trap_instruction,
  input wire logic service_ack,
  input wire logic maskable_req,
  input wire logic nonmaskable_req,
  input wire logic [15:0] vector_addr,
  input wire logic vector_valid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // four samples cover the two synchroniser stages plus the request register
  sequence s_nmi_held;
    (!nonmaskable_request_pin_n && !cpu_x_mask) [*4];
  endsequence

  sequence s_nmi_top;
    service_ack && !software_trap_instruction && !illegal_opcode && !watchdog_fail
      && !clkmon_fail;
  endsequence

  a_valid_follows: assert property (service_ack |=> vector_valid)
    else $error("no vector strobe after service");
  a_valid_single: assert property (!service_ack |=> !vector_valid)
    else $error("vector strobe without service");
  a_vector_holds: assert property (!service_ack |=> $stable(vector_addr))
    else $error("vector changed without service");
  a_wdog_vector: assert property (service_ack && watchdog_fail && !clkmon_fail
    |=> vector_addr == 16'hfffa) else $error("watchdog vector wrong");
  a_trap_vector: assert property (service_ack && illegal_opcode && !watchdog_fail
    && !clkmon_fail |=> vector_addr == 16'hfff8) else $error("trap vector wrong");
  a_swi_vector: assert property (service_ack && software_trap_instruction
    && !illegal_opcode && !watchdog_fail && !clkmon_fail |=> vector_addr == 16'hfff6)
    else $error("software trap vector wrong");
  a_nmi_vector: assert property (s_nmi_held ##0 s_nmi_top
    |=> vector_addr == 16'hfff4) else $error("x pin vector wrong");
  a_nmi_level: assert property (s_nmi_held |-> nonmaskable_req)
    else $error("held x pin not requesting");
  a_mask_quiet: assert property (cpu_i_mask [*2] |-> !maskable_req)
    else $error("maskable request while masked");
endmodule // ilv_asserts

bind ilv_top ilv_asserts u_chk
(
  .hclk(hclk), .hresetn(hresetn), .nonmaskable_request_pin_n(nonmaskable_request_pin_n),
  .cpu_x_mask(cpu_x_mask), .cpu_i_mask(cpu_i_mask), .clkmon_fail(clkmon_fail),
  .watchdog_fail(watchdog_fail), .illegal_opcode(illegal_opcode),
  .software_trap_instruction(software_trap_instruction), .service_ack(service_ack),
  .maskable_req(maskable_req), .nonmaskable_req(nonmaskable_req),
  .vector_addr(vector_addr), .vector_valid(vector_valid)
);

// *** sim/ilv_partner.sv ***
// model of the external logic that drives both request pins
`timescale 1ns/10ps

module ilv_partner
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] cmd,
  output logic irq_pin_n,
  output logic nmi_pin_n
);
  // pins stay low until cmd bit 2 releases both; the model never sees the service handshake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_pin_n <= 1'h1;
      nmi_pin_n <= 1'h1;
    end
    else if (cmd[2])
    begin
      irq_pin_n <= 1'h1;
      nmi_pin_n <= 1'h1;
    end
    else
    begin
      if (cmd[0])
        irq_pin_n <= 1'h0;
      if (cmd[1])
        nmi_pin_n <= 1'h0;
    end
  end
endmodule // ilv_partner

// *** sim/interrupt_latch_vector_map_tb_top.sv ***
// register and service sequence bench of the interrupt latch and vector map
`timescale 1ns/10ps
`include "ilv_defs.svh"

module interrupt_latch_vector_map_tb_top;
  logic hclk;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [23:1] periph_event = 23'h0;
  logic clkmon_fail = 1'h0;
  logic watchdog_fail = 1'h0;
  logic cpu_i_mask = 1'h1;
  logic cpu_x_mask = 1'h0;
  logic software_trap_instruction = 1'h0;
  logic illegal_opcode = 1'h0;
  logic service_ack = 1'h0;
  logic [2:0] cmd = 3'h0;
  logic [7:0] ev [4] = '{8'hda, 8'hd8, 8'hcc, 8'hca};
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, maskable_req, nonmaskable_req, vector_valid, irq_out;
  wire logic irq_n, nmi_n;
  wire logic [15:0] vector_addr;
  wire logic [15:0] vector_addr_can;
  wire logic hready = hreadyout;
  int fails = 0;
  int total_checks = 0;

  ilv_top uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nonmaskable_request_pin_n(nmi_n),
    .maskable_request_pin_n(irq_n), .periph_event(periph_event),
    .clkmon_fail(clkmon_fail), .watchdog_fail(watchdog_fail), .special_mode(1'h0),
    .cpu_i_mask(cpu_i_mask), .cpu_x_mask(cpu_x_mask),
    .software_trap_instruction(software_trap_instruction),
    .illegal_opcode(illegal_opcode), .service_ack(service_ack),
    .maskable_req(maskable_req), .nonmaskable_req(nonmaskable_req),
    .vector_addr(vector_addr), .vector_valid(vector_valid), .irq_out(irq_out)
  );

  // the alternate map sees the same inputs; only its vector is watched
  ilv_top #(.CAN_MAP(1'b1)) uut_can
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(),
    .hreadyout(), .hresp(), .nonmaskable_request_pin_n(nmi_n),
    .maskable_request_pin_n(irq_n), .periph_event(periph_event),
    .clkmon_fail(clkmon_fail), .watchdog_fail(watchdog_fail), .special_mode(1'h0),
    .cpu_i_mask(cpu_i_mask), .cpu_x_mask(cpu_x_mask),
    .software_trap_instruction(software_trap_instruction),
    .illegal_opcode(illegal_opcode), .service_ack(service_ack),
    .maskable_req(), .nonmaskable_req(), .vector_addr(vector_addr_can),
    .vector_valid(), .irq_out()
  );

  ilv_partner u_far
  (
    .clk(hclk), .rst_n(hresetn), .cmd(cmd), .irq_pin_n(irq_n), .nmi_pin_n(nmi_n)
  );

  initial
  begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // read data is taken at the edge that closes the data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= `ILV_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task svc(input logic [15:0] e);
    @(posedge hclk);
    service_ack <= 1'h1;
    @(posedge hclk);
    service_ack <= 1'h0;
    @(posedge hclk);
    chk({31'h0, vector_valid}, 32'h1);
    chk({16'h0, vector_addr}, {16'h0, e});
  endtask

  // the mask is raised around the write, the only time it may land
  task elev(input logic [7:0] v);
    cpu_i_mask <= 1'h1;
    bus(1'h1, `ILV_OFS_ELEV, {24'h0, v});
    cpu_i_mask <= 1'h0;
  endtask

  task far(input logic [2:0] c);
    cmd <= c;
    wt(1);
    cmd <= 3'h0;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    fails++;
    wrap_up();
  end

  initial
  begin
    wt(5);
    hresetn <= 1'h1;
    bus(1'h0, `ILV_OFS_CTRL, 32'h0);
    chk(rd, 32'h2);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    bus(1'h0, `ILV_OFS_ELEV, 32'h0);
    chk(rd, 32'hf2);
    bus(1'h0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    chk({16'h0, vector_addr}, 32'hfffe);
    cpu_i_mask <= 1'h0;
    bus(1'h1, `ILV_OFS_ELEV, 32'hd8);
    bus(1'h0, `ILV_OFS_ELEV, 32'h0);
    chk(rd, 32'hf2);
    bus(1'h1, `ILV_OFS_LOCAL_EN, 32'h183000);
    periph_event <= 23'h0c1800;
    wt(1);
    periph_event <= 23'h0;
    wt(3);
    chk({31'h0, maskable_req}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      elev(ev[i]);
      svc({8'hff, ev[i]});
      chk({16'h0, vector_addr_can}, {16'h0, 8'hff, (i < 2) ? ev[i] : 8'hda});
    end
    elev(8'hf0);
    svc(16'hffda);
    bus(1'h0, `ILV_OFS_FLAGS, 32'h0);
    chk(rd, 32'h183000);
    far(3'h1);
    wt(4);
    elev(8'hc0);
    svc(16'hfff2);
    far(3'h4);
    bus(1'h1, `ILV_OFS_FLAG_CLR, 32'hffffff);
    svc(16'hfff8);
    bus(1'h0, `ILV_OFS_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    bus(1'h1, `ILV_OFS_INT_EN, 32'h1);
    wt(2);
    chk({31'h0, irq_out}, 32'h1);
    bus(1'h1, `ILV_OFS_INT_EN, 32'h0);
    wt(2);
    chk({31'h0, irq_out}, 32'h0);
    bus(1'h1, `ILV_OFS_INT_EN, 32'h1);
    bus(1'h1, `ILV_OFS_INT_CLR, 32'h1);
    wt(2);
    chk({31'h0, irq_out}, 32'h0);
    bus(1'h1, `ILV_OFS_CTRL, 32'h3);
    far(3'h1);
    wt(4);
    far(3'h4);
    wt(4);
    bus(1'h0, `ILV_OFS_PINS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    bus(1'h0, `ILV_OFS_INT_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    svc(16'hfff2);
    bus(1'h0, `ILV_OFS_PINS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    far(3'h2);
    wt(4);
    svc(16'hfff4);
    software_trap_instruction <= 1'h1;
    svc(16'hfff6);
    illegal_opcode <= 1'h1;
    svc(16'hfff8);
    watchdog_fail <= 1'h1;
    svc(16'hfffa);
    bus(1'h1, `ILV_OFS_CTRL, 32'h7);
    clkmon_fail <= 1'h1;
    svc(16'hfffc);
    chk({31'h0, nonmaskable_req}, 32'h1);
    wrap_up();
  end
endmodule // interrupt_latch_vector_map_tb_top
